// ---- sarcfg_regs.vh ----
// sarcfg_regs.vh: addresses, field positions, reset values and codes
// assumes: included by the converter configuration design files
`ifndef SARCFG_REGS_VH
`define SARCFG_REGS_VH
// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define SARCFG_ADDR_ACC 8'hba
`define SARCFG_ADDR_CFG 8'hbc
`define SARCFG_ADDR_RES_L 8'hbd
`define SARCFG_ADDR_RES_H 8'hbe
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SARCFG_CFG_RESET 8'hf8
`define SARCFG_ACC_RESET 8'h00
// ----------------------------------------------------------------------
// converter configuration fields
// ----------------------------------------------------------------------
`define SARCFG_DIV_HI 7
`define SARCFG_DIV_LO 3
`define SARCFG_EIGHT_BIT 2
`define SARCFG_DELAY_TRACK 1
`define SARCFG_GAIN 0
// ----------------------------------------------------------------------
// accumulator configuration fields
// ----------------------------------------------------------------------
`define SARCFG_TWELVE_BIT 7
`define SARCFG_ACCUMULATE 6
`define SARCFG_SJ_HI 5
`define SARCFG_SJ_LO 3
`define SARCFG_RPT_HI 2
`define SARCFG_RPT_LO 0
// ----------------------------------------------------------------------
// codes and timing
// ----------------------------------------------------------------------
`define SARCFG_SJ_LEFT 3'h4
`define SARCFG_RES_10 2'h0
`define SARCFG_RES_8 2'h1
`define SARCFG_RES_12 2'h2
`define SARCFG_TRACK_CYCLES 2'h3
`define SARCFG_ONE8 8'h01
`define SARCFG_ZERO8 8'h00
`endif

// ---- sarcfg_clk_div.v ----
// sarcfg_clk_div.v: divides a source clock tick stream by field plus one
// assumes: src_tick is a one-cycle pulse on clk for each source period
`default_nettype none
`include "sarcfg_regs.vh"

module sarcfg_clk_div #(
   parameter WIDTH = 5
) (
   input wire clk,
   input wire rst_n,
   input wire src_tick,
   input wire [WIDTH-1:0] divide,
   output reg sar_tick
);
   reg [WIDTH-1:0] count;

   // ----------------------------------------------------------------------
   // count source ticks, pulse once every divide+1 ticks
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= {WIDTH{1'b0}};
         sar_tick <= 1'b0;
      end else begin
         sar_tick <= 1'b0;
         if (src_tick) begin
            if (count >= divide) begin
               count <= {WIDTH{1'b0}};
               sar_tick <= 1'b1;
            end else begin
               count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- sarcfg_top.v ----
// sarcfg_top.v: converter configuration, accumulator and result formatting
// assumes: a byte-wide special register port on clk; the analog converter
// outside accepts start pulses and returns one result per conversion
`default_nettype none
`include "sarcfg_regs.vh"

module sarcfg_top #(
   parameter DIV_WIDTH = 5,
   parameter ACC_WIDTH = 16,
   parameter RES_WIDTH = 12
) (
   input wire clk,
   input wire rst_n,
   input wire sys_clk_tick,
   input wire lpo_clk_pin,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire converter_on,
   input wire burst_select,
   input wire start_conv,
   input wire done_clear,
   input wire conv_result_valid,
   input wire [RES_WIDTH-1:0] conv_result,
   output reg conv_start,
   output reg tracking,
   output reg sar_conversion_clock,
   output reg [1:0] resolution,
   output reg pga_gain_select,
   output reg conversion_done_flag
);
   // ----------------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_TRACK = 3'b010;
   localparam ST_CONV = 3'b100;

   reg [7:0] converter_config_reg;
   reg twelve_bit_select;
   reg accumulate_select;
   reg [2:0] shift_justify_field;
   reg [2:0] repeat_count_field;
   reg [ACC_WIDTH-1:0] acc;
   reg [2:0] state;
   reg [1:0] track_cnt;
   reg [6:0] conv_left;
   reg burst_run;
   reg lpo_s1, lpo_s2, lpo_s3;
   reg [ACC_WIDTH-1:0] next_acc;
   reg [ACC_WIDTH-1:0] fmt;
   reg [6:0] rpt_total;
   wire src_tick;
   wire sar_tick;
   wire [DIV_WIDTH-1:0] sar_clock_divider;
   wire eight_bit_select;
   wire delayed_track_select;

   assign sar_clock_divider =
      converter_config_reg[`SARCFG_DIV_HI:`SARCFG_DIV_LO];
   assign eight_bit_select = converter_config_reg[`SARCFG_EIGHT_BIT];
   assign delayed_track_select = converter_config_reg[`SARCFG_DELAY_TRACK];

   // ----------------------------------------------------------------------
   // source clock select and divider
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lpo_s1 <= 1'b0;
         lpo_s2 <= 1'b0;
         lpo_s3 <= 1'b0;
      end else begin
         lpo_s1 <= lpo_clk_pin;
         lpo_s2 <= lpo_s1;
         lpo_s3 <= lpo_s2;
      end
   end

   assign src_tick = burst_select ? (lpo_s2 & ~lpo_s3)
                                  : sys_clk_tick;

   sarcfg_clk_div #(
      .WIDTH(DIV_WIDTH)
   ) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .src_tick(src_tick),
      .divide(sar_clock_divider),
      .sar_tick(sar_tick)
   );

   // ----------------------------------------------------------------------
   // repeat count decode and accumulation
   // ----------------------------------------------------------------------
   always @* begin
      case (repeat_count_field)
         3'h0: rpt_total = 7'h01;
         3'h1: rpt_total = 7'h04;
         3'h2: rpt_total = 7'h08;
         3'h3: rpt_total = 7'h10;
         3'h4: rpt_total = 7'h20;
         3'h5: rpt_total = 7'h40;
         default: rpt_total = 7'h01;
      endcase
   end

   always @* begin
      next_acc = acc;
      if (conv_result_valid && state == ST_CONV) begin
         if (burst_run) begin
            if (conv_left == rpt_total)
               next_acc = {{(ACC_WIDTH-RES_WIDTH){1'b0}}, conv_result};
            else
               next_acc = acc + {{(ACC_WIDTH-RES_WIDTH){1'b0}},
                                 conv_result};
         end else if (accumulate_select) begin
            next_acc = acc + {{(ACC_WIDTH-RES_WIDTH){1'b0}},
                              conv_result};
         end else begin
            next_acc = {{(ACC_WIDTH-RES_WIDTH){1'b0}}, conv_result};
         end
      end
   end

   // ----------------------------------------------------------------------
   // read formatting of the stored sum
   // ----------------------------------------------------------------------
   always @* begin
      case (shift_justify_field)
         3'h0: fmt = acc;
         3'h1: fmt = acc >> 1;
         3'h2: fmt = acc >> 2;
         3'h3: fmt = acc >> 3;
         `SARCFG_SJ_LEFT: begin
            if (twelve_bit_select)
               fmt = acc << (ACC_WIDTH - 12);
            else if (eight_bit_select)
               fmt = acc << (ACC_WIDTH - 8);
            else
               fmt = acc << (ACC_WIDTH - 10);
         end
         default: fmt = acc;
      endcase
   end

   // ----------------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_config_reg <= `SARCFG_CFG_RESET;
         twelve_bit_select <= 1'b0;
         accumulate_select <= 1'b0;
         shift_justify_field <= 3'h0;
         repeat_count_field <= 3'h0;
         reg_rdata <= `SARCFG_ZERO8;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `SARCFG_ADDR_CFG: converter_config_reg <= reg_wdata;
               `SARCFG_ADDR_ACC: begin
                  twelve_bit_select <= reg_wdata[`SARCFG_TWELVE_BIT];
                  accumulate_select <= reg_wdata[`SARCFG_ACCUMULATE];
                  shift_justify_field <=
                     reg_wdata[`SARCFG_SJ_HI:`SARCFG_SJ_LO];
                  repeat_count_field <=
                     reg_wdata[`SARCFG_RPT_HI:`SARCFG_RPT_LO];
               end
               default: ;
            endcase
         end
         if (reg_rd) begin
            case (reg_addr)
               `SARCFG_ADDR_CFG: reg_rdata <= converter_config_reg;
               `SARCFG_ADDR_ACC:
                  reg_rdata <= {twelve_bit_select, 1'b0,
                                shift_justify_field, repeat_count_field};
               `SARCFG_ADDR_RES_L: reg_rdata <= fmt[7:0];
               `SARCFG_ADDR_RES_H: reg_rdata <= fmt[15:8];
               default: reg_rdata <= `SARCFG_ZERO8;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // accumulator storage: a written result byte replaces that byte
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= {ACC_WIDTH{1'b0}};
      end else if (reg_wr && reg_addr == `SARCFG_ADDR_RES_L) begin
         acc <= {acc[ACC_WIDTH-1:8], reg_wdata};
      end else if (reg_wr && reg_addr == `SARCFG_ADDR_RES_H) begin
         acc <= {reg_wdata, acc[7:0]};
      end else begin
         acc <= next_acc;
      end
   end

   // ----------------------------------------------------------------------
   // start sequencing: tracking delay and burst counting
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         track_cnt <= 2'h0;
         conv_left <= 7'h00;
         burst_run <= 1'b0;
         conv_start <= 1'b0;
         tracking <= 1'b0;
         conversion_done_flag <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         if (done_clear)
            conversion_done_flag <= 1'b0;
         case (state)
            ST_IDLE: begin
               tracking <= 1'b1;
               if (start_conv && (converter_on || burst_select)) begin
                  burst_run <= burst_select;
                  conv_left <= burst_select ? rpt_total : 7'h01;
                  track_cnt <= 2'h0;
                  if (delayed_track_select) begin
                     state <= ST_TRACK;
                  end else begin
                     state <= ST_CONV;
                     conv_start <= 1'b1;
                     tracking <= 1'b0;
                  end
               end
            end
            ST_TRACK: begin
               if (sar_tick) begin
                  if (track_cnt == `SARCFG_TRACK_CYCLES - 2'h1) begin
                     state <= ST_CONV;
                     conv_start <= 1'b1;
                     tracking <= 1'b0;
                  end else begin
                     track_cnt <= track_cnt + 2'h1;
                  end
               end
            end
            ST_CONV: begin
               if (conv_result_valid) begin
                  tracking <= 1'b1;
                  if (conv_left == 7'h01) begin
                     state <= ST_IDLE;
                     conversion_done_flag <= 1'b1;
                  end else begin
                     conv_left <= conv_left - 7'h01;
                     track_cnt <= 2'h0;
                     if (delayed_track_select) begin
                        state <= ST_TRACK;
                     end else begin
                        conv_start <= 1'b1;
                        tracking <= 1'b0;
                     end
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // configuration outputs to the analog side
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sar_conversion_clock <= 1'b0;
         resolution <= `SARCFG_RES_10;
         pga_gain_select <= 1'b0;
      end else begin
         sar_conversion_clock <= sar_tick;
         if (twelve_bit_select)
            resolution <= `SARCFG_RES_12;
         else if (eight_bit_select)
            resolution <= `SARCFG_RES_8;
         else
            resolution <= `SARCFG_RES_10;
         pga_gain_select <= converter_config_reg[`SARCFG_GAIN];
      end
   end
endmodule
`default_nettype wire

// ---- sarcfg_top_properties.sv ----
// sarcfg_top_properties.sv: port assertions for sarcfg_top
// assumes: registers change only by reg_wr on the byte port
`default_nettype none
module sarcfg_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sys_clk_tick,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic converter_on,
   input wire logic burst_select,
   input wire logic start_conv,
   input wire logic done_clear,
   input wire logic conv_result_valid,
   input wire logic conv_start,
   input wire logic sar_conversion_clock,
   input wire logic [1:0] resolution,
   input wire logic pga_gain_select,
   input wire logic conversion_done_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // shadow state
   // ------------------------------------------------------------------
   logic [7:0] cfg;
   logic [7:0] acc;
   logic active;
   logic dpend;
   logic svld;
   logic [2:0] dcnt;
   logic [5:0] scnt;
   wire logic take;
   assign take = start_conv && (converter_on || burst_select) && !active;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= 8'hf8;
         acc <= 8'h00;
         active <= 1'b0;
         dpend <= 1'b0;
         svld <= 1'b0;
         dcnt <= 3'h0;
         scnt <= 6'h00;
      end else begin
         if (reg_wr && reg_addr == 8'hbc)
            cfg <= reg_wdata;
         if (reg_wr && reg_addr == 8'hba)
            acc <= reg_wdata;
         if (take)
            active <= 1'b1;
         else if ($rose(conversion_done_flag))
            active <= 1'b0;
         dpend <= take ? cfg[1] : dpend && !conv_start;
         dcnt <= take ? 3'h0 :
            dcnt + {2'h0, sar_conversion_clock && dcnt != 3'h7};
         svld <= !(reg_wr || burst_select) && scnt != 6'h3f &&
            (svld || sar_conversion_clock);
         scnt <= sar_conversion_clock ? 6'h00 :
            scnt + {5'h0, sys_clk_tick && scnt != 6'h3f};
      end
   end
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_acc_bit6;
      reg_rd && reg_addr == 8'hba |=> !reg_rdata[6];
   endproperty
   a_acc_bit6: assert property (p_acc_bit6)
      else $error("accumulate bit read back as one");
   property p_norm_start;
      take && !cfg[1] && !burst_select |=> conv_start;
   endproperty
   a_norm_start: assert property (p_norm_start)
      else $error("normal track start late");
   property p_delay_start;
      conv_start && dpend |->
         dcnt == 3'h3 || (dcnt == 3'h2 && sar_conversion_clock);
   endproperty
   a_delay_start: assert property (p_delay_start)
      else $error("delayed start not after three clocks");
   property p_done_set;
      conv_result_valid && active && !burst_select |=> conversion_done_flag;
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag not set after conversion");
   property p_done_clear;
      done_clear && !conv_result_valid |=> !conversion_done_flag;
   endproperty
   a_done_clear: assert property (p_done_clear)
      else $error("done flag not cleared");
   property p_res_sel;
      !$past(reg_wr) |->
         resolution == (acc[7] ? 2'h2 : {1'b0, cfg[2]});
   endproperty
   a_res_sel: assert property (p_res_sel)
      else $error("resolution does not follow config");
   property p_gain;
      !$past(reg_wr) |-> pga_gain_select == cfg[0];
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain does not follow config");
   property p_sar_div;
      sar_conversion_clock && svld && !burst_select |->
         {1'b0, scnt} + {6'h0, sys_clk_tick} == {2'h0, cfg[7:3]} + 7'h1;
   endproperty
   a_sar_div: assert property (p_sar_div)
      else $error("conversion clock period wrong");
endmodule
bind sarcfg_top sarcfg_checker chk (.*);
`default_nettype wire

// ---- sarcfg_top_bench.sv ----
// sarcfg_top_bench.sv: self-checking bench for sarcfg_top
// assumes: design and checker files compiled first
`default_nettype none
module sarcfg_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sys_clk_tick = 1'b1;
   logic lpo_clk_pin = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic converter_on = 1'b0;
   logic burst_select = 1'b0;
   logic start_conv = 1'b0;
   logic done_clear = 1'b0;
   logic conv_result_valid = 1'b0;
   logic [11:0] conv_result = 12'h000;
   wire logic [7:0] reg_rdata;
   wire logic conv_start;
   wire logic tracking;
   wire logic sar_conversion_clock;
   wire logic [1:0] resolution;
   wire logic pga_gain_select;
   wire logic conversion_done_flag;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [15:0] sum;
   logic [15:0] s1;
   logic [15:0] r16;
   logic [7:0] v;
   logic [7:0] a;
   logic [7:0] r8;
   sarcfg_top DUT (.*);
   always #2.5 clk = ~clk;
   always #25 lpo_clk_pin = ~lpo_clk_pin;
   always @(posedge clk) #1 sys_clk_tick = ~sys_clk_tick;
   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      reg_addr = ad;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask
   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      reg_addr = ad;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      d = reg_rdata;
      tick();
   endtask
   task automatic wait_hi(input bit done);
      int n;
      n = 0;
      while ((done ? conversion_done_flag : conv_start) !== 1'b1 &&
         n < 400) begin
         tick();
         n++;
      end
      check("wait", 16'h1, {15'h0, n < 400});
   endtask
   task automatic run(input int n, output logic [15:0] s);
      logic [11:0] r;
      s = 16'h0000;
      start_conv = 1'b1;
      tick();
      start_conv = 1'b0;
      for (int i = 0; i < n; i++) begin
         wait_hi(1'b0);
         check("tracking", 16'h0, {15'h0, tracking});
         r = 12'($urandom) & 12'h3ff;
         tick(2);
         conv_result = r;
         conv_result_valid = 1'b1;
         tick();
         conv_result_valid = 1'b0;
         s = s + {4'h0, r};
      end
      wait_hi(1'b1);
      check("tracking", 16'h1, {15'h0, tracking});
      done_clear = 1'b1;
      tick();
      done_clear = 1'b0;
      check("done", 16'h0, {15'h0, conversion_done_flag});
   endtask
   function automatic logic [15:0] fmt(input logic [15:0] s, input int j);
      if (j < 4)
         return s >> j;
      return j == 4 ? s << 6 : s;
   endfunction
   // ------------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'hb810));
      tick(12);
      rst_n = 1'b1;
      tick();
      rd(8'hbc, v);
      check("cfg reset", 16'hf8, {8'h0, v});
      rd(8'hba, v);
      check("acc reset", 16'h0, {8'h0, v});
      rd(8'hbb, v);
      check("unmapped", 16'h0, {8'h0, v});
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom);
         a = 8'($urandom) & 8'hf8;
         if (a[7])
            v[2] = 1'b0;
         wr(8'hbc, v);
         wr(8'hba, a);
         rd(8'hbc, r8);
         check("cfg", {8'h0, v}, {8'h0, r8});
         rd(8'hba, r8);
         check("acc", {8'h0, a & 8'hbf}, {8'h0, r8});
         r16 = a[7] ? 16'h2 : {15'h0, v[2]};
         check("res", r16, {14'h0, resolution});
         check("gain", {15'h0, v[0]}, {15'h0, pga_gain_select});
      end
      wr(8'hbc, 8'h08);
      wr(8'hba, 8'h00);
      converter_on = 1'b1;
      for (int i = 0; i < 3; i++) begin
         run(1, sum);
         rd(8'hbe, r16[15:8]);
         rd(8'hbd, r16[7:0]);
         check("single", sum, r16);
      end
      wr(8'hba, 8'h40);
      wr(8'hbd, 8'h00);
      wr(8'hbe, 8'h00);
      sum = 16'h0;
      for (int i = 0; i < 3; i++) begin
         run(1, s1);
         sum = sum + s1;
      end
      for (int j = 0; j < 6; j++) begin
         if (j > 0)
            wr(8'hba, 8'(j << 3));
         rd(8'hbe, r16[15:8]);
         rd(8'hbd, r16[7:0]);
         check("format", fmt(sum, j), r16);
      end
      // left justify at 8-bit and at 12-bit resolution
      wr(8'hbc, 8'h0c);
      for (int j = 0; j < 2; j++) begin
         wr(8'hba, j ? 8'ha0 : 8'h20);
         rd(8'hbe, r16[15:8]);
         rd(8'hbd, r16[7:0]);
         check("left", j ? sum << 4 : sum << 8, r16);
      end
      wr(8'hbc, 8'h0a);
      run(1, sum);
      wr(8'hbc, 8'h08);
      burst_select = 1'b1;
      for (int k = 0; k < 7; k++) begin
         wr(8'hba, 8'(k));
         run((k == 0 || k > 5) ? 1 : 2 << k, sum);
         rd(8'hbe, r16[15:8]);
         rd(8'hbd, r16[7:0]);
         check("burst", sum, r16);
      end
      // burst with delayed tracking runs on the oscillator ticks
      wr(8'hbc, 8'h0a);
      wr(8'hba, 8'h01);
      run(4, sum);
      rd(8'hbe, r16[15:8]);
      rd(8'hbd, r16[7:0]);
      check("burst track", sum, r16);
      stop_test();
   end
endmodule
`default_nettype wire
